//--- rtl/rtc_periodic_pkg.sv
// Shared constants and types for the periodic interrupt and status block.
package rtc_periodic_pkg;

   // Core clock rate in hertz (4 ns period).
   localparam int CLOCK_HZ = 250_000_000;
   // One quarter of a second, in milliseconds, and in core cycles.
   localparam int QUARTER_SECOND_MS = 250;
   localparam int QUARTER_CYCLES = CLOCK_HZ / 1000 * QUARTER_SECOND_MS;
   // Lag of the second increment behind the pulse falling edge.
   localparam int INC_DELAY_US = 92;
   localparam int INC_DELAY_CYCLES = CLOCK_HZ / 1_000_000 * INC_DELAY_US;
   // Largest period change made by one adjustment step, in ns and cycles.
   localparam int ADJ_MAX_NS = 3_784_000;
   localparam int ADJ_MAX_CYCLES = CLOCK_HZ / 1_000_000 * ADJ_MAX_NS / 1000;
   // Cycles per unit of the adjustment magnitude (63 units reach the maximum).
   localparam int ADJ_STEP_CYCLES = ADJ_MAX_CYCLES / 63;
   // Adjustment intervals in seconds, selected by the step select bit.
   localparam logic [5:0] ADJ_FINE_PERIOD_S = 6'h14;
   localparam logic [5:0] ADJ_COARSE_PERIOD_S = 6'h3c;
   // Last value of the seconds counter before it wraps.
   localparam logic [5:0] SECONDS_LAST = 6'h3b;

   // Register indices; the byte address is four times the index.
   localparam logic [3:0] SECONDS_IDX = 4'h0;
   localparam logic [3:0] ADJUST_IDX = 4'h7;
   localparam logic [3:0] CONTROL_ONE_IDX = 4'he;
   localparam logic [3:0] CONTROL_STATUS_TWO_IDX = 4'hf;

   // Field positions.
   localparam int TEST_BIT = 3;
   localparam int THRESHOLD_BIT = 7;
   localparam int LOW_VOLTAGE_BIT = 6;
   localparam int OSC_STATUS_BIT = 5;
   localparam int POWER_ON_BIT = 4;
   localparam int SPARE_ONE_BIT = 3;
   localparam int PERIODIC_FLAG_BIT = 2;
   localparam int ADJ_STEP_BIT = 7;
   localparam int ADJ_SIGN_BIT = 6;

   // Reset values.
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic POWER_ON_RESET = 1'b1;
   localparam logic OSC_STATUS_RESET = 1'b0;

   // Periodic output modes.
   typedef enum logic [2:0] {
      MODE_OFF = 3'b000,
      MODE_FIXED_LOW = 3'b001,
      MODE_PULSE_2HZ = 3'b010,
      MODE_PULSE_1HZ = 3'b011,
      MODE_EVERY_SECOND = 3'b100,
      MODE_EVERY_MINUTE = 3'b101,
      MODE_EVERY_HOUR = 3'b110,
      MODE_EVERY_MONTH = 3'b111
   } periodic_mode_t;

   // Bus slave states.
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_WAIT = 1'b1
   } bus_state_t;

endpackage : rtc_periodic_pkg

//--- rtl/level_sync.sv
// Two flip-flop synchroniser for a group of asynchronous levels.
`timescale 1ns/100ps
module level_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // First stage, read only by the second stage.
   logic [WIDTH-1:0] stage_one;

   // Both stages clear on reset and then follow the pins.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         stage_one <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage_one <= async_in;
         sync_out <= stage_one;
      end
   end

endmodule : level_sync

//--- rtl/subsecond_divider.sv
// Sub-second divider that splits each second into four equal quarters.
`timescale 1ns/100ps
module subsecond_divider #(
   parameter int QUARTER = 62_500_000,
   parameter int CW = 27
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic clear,
   input wire logic stretch,
   input wire logic hurry,
   output logic [CW-1:0] count,
   output logic [1:0] quarter
);

   // Sum one bit wider than the count so the wrap test cannot overflow.
   logic [CW:0] next_count;

   // Step by two while hurrying, by one otherwise.
   always_comb
   begin
      next_count = {1'b0, count} + (hurry ? (CW+1)'(2) : (CW+1)'(1));
   end

   // Clear restarts the second; stretch holds; wrap steps the quarter.
   always_ff @(posedge clock)
   begin
      if (rst || clear)
      begin
         count <= '0;
         quarter <= 2'h0;
      end
      else if (!stretch)
      begin
         if (next_count >= (CW+1)'(QUARTER))
         begin
            count <= CW'(next_count - (CW+1)'(QUARTER));
            quarter <= quarter + 2'h1;
         end
         else
         begin
            count <= CW'(next_count);
         end
      end
   end

endmodule : subsecond_divider

//--- rtl/rtc_periodic_irq.sv
// Periodic interrupt generator and control/status registers on AHB-Lite.
//
// Summary of operation
// - Test bit: 0 normal, 1 test mode.
// - Code 000 output high; 001 output low.
// - Codes 010/011 give 2 Hz/1 Hz square waves.
// - Second increments 92 us after pulse falls.
// - Seconds write clears divider; pulse output low.
// - Codes 1xx: each second, minute, hour, month.
// - Level output falls with the second increment.
// - Brief low after select write; check flag.
// - Adjustment shifts period every 20/60 s, 3.784 ms.
// - Threshold select: 0 is 2.1 V, 1 is 1.35 V.
// - Low-voltage flag sticks, monitor stopped, until cleared.
// - Writing 0 clears flag, restarts monitor; 1 ignored.
// - Oscillator status read/write; halt forces and keeps 0.
// - Power-on flag sets at power-up, stays set.
// - Power-on flag zeroes control bits, stops output.
// - Power-on flag clears only on writing 0.
// - Spare bit stores writes; zeroed by power-on flag.
// - Select in control one bits 2:0, test bit 3.
// - Periodic flag mirrors low output; write 0 releases.
`timescale 1ns/100ps
module rtc_periodic_irq
   import rtc_periodic_pkg::*;
#(
   parameter int QUARTER = rtc_periodic_pkg::QUARTER_CYCLES,
   parameter int INC_DELAY = rtc_periodic_pkg::INC_DELAY_CYCLES,
   parameter int ADJ_STEP = rtc_periodic_pkg::ADJ_STEP_CYCLES
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic supply_below_high,
   input wire logic supply_below_low,
   input wire logic osc_halt_sense,
   input wire logic power_up_detect,
   input wire logic minute_is_zero,
   input wire logic hour_is_zero,
   input wire logic day_is_first,
   output logic irq_out_n,
   output logic supply_threshold_select,
   output logic monitor_enable,
   output logic test_mode,
   output logic adjust_step_select,
   output logic second_tick
);

   import rtc_periodic_pkg::*;

   // Divider and stall counter widths.
   localparam int CW = $clog2(QUARTER + 2);
   localparam int SW = $clog2(63 * ADJ_STEP + 1);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.

   bus_state_t state; // Bus slave state.
   logic p_write; // Pending transfer is a write.
   logic p_hit; // Pending address lies in the register window.
   logic [3:0] p_idx; // Pending register index.
   logic wr_en; // Write strobe during the wait cycle, the first data-phase cycle.
   logic [7:0] wdata; // Written byte.
   logic [7:0] control_one; // Select, test bit and plain storage bits.
   logic [7:0] adjust; // Oscillation adjustment register.
   logic [5:0] seconds; // Seconds counter, binary 0 to 59.
   logic supply_threshold; // Threshold select bit.
   logic low_voltage_flag; // Sticky low-voltage flag.
   logic osc_running_status; // Oscillator status bit.
   logic power_on_flag; // Power-on flag.
   logic spare_bit_one; // Scratch bit.
   logic level_latch; // Level-mode request held until released.
   logic [3:0] pins; // Synchronised analog and sense pins.
   logic [CW-1:0] div_count; // Count within the current quarter.
   logic [1:0] quarter; // Quarter of the second.
   logic [SW-1:0] stall; // Remaining adjustment cycles.
   logic second_inc; // Seconds counter increments this cycle.
   logic level_event; // Level-mode interrupt moment.
   logic periodic_low; // Wanted output state, high meaning asserted.
   logic [7:0] read_mux; // Read data for the pending index.
   periodic_mode_t periodic_select; // Decoded select field.
   logic wr_seconds, wr_adjust, wr_one, wr_two; // Per-register write strobes.

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave: one wait state on every transfer, always OKAY.

   // Writes land at the end of the wait cycle, with hwdata valid.
   always_comb
   begin
      wdata = hwdata[7:0];
      wr_en = (state == BUS_WAIT) && p_write && p_hit;
      wr_seconds = wr_en && (p_idx == SECONDS_IDX);
      wr_adjust = wr_en && (p_idx == ADJUST_IDX);
      wr_one = wr_en && (p_idx == CONTROL_ONE_IDX);
      wr_two = wr_en && (p_idx == CONTROL_STATUS_TWO_IDX);
   end

   // Address phase capture and ready handshake.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state <= BUS_IDLE;
         hreadyout <= 1'b1;
         p_write <= 1'b0;
         p_hit <= 1'b0;
         p_idx <= 4'h0;
      end
      else
      begin
         case (state)
            BUS_IDLE:
            begin
               if (hsel && htrans[1] && hready)
               begin
                  state <= BUS_WAIT;
                  hreadyout <= 1'b0;
                  p_write <= hwrite;
                  p_hit <= (haddr[31:6] == 26'h0) && (haddr[1:0] == 2'h0);
                  p_idx <= haddr[5:2];
               end
            end
            default:
            begin
               state <= BUS_IDLE;
               hreadyout <= 1'b1;
            end
         endcase
      end
   end

   // Read multiplexer; unmapped words and alarm bits read zero.
   always_comb
   begin
      if (!p_hit)
         read_mux = 8'h00;
      else if (p_idx == SECONDS_IDX)
         read_mux = {2'h0, seconds};
      else if (p_idx == ADJUST_IDX)
         read_mux = adjust;
      else if (p_idx == CONTROL_ONE_IDX)
         read_mux = control_one;
      else if (p_idx == CONTROL_STATUS_TWO_IDX)
         read_mux = {supply_threshold, low_voltage_flag, osc_running_status,
                     power_on_flag, spare_bit_one, !irq_out_n, 2'h0};
      else
         read_mux = 8'h00;
   end

   // Read data registered at the end of the wait cycle; response always OKAY.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         hrdata <= 32'h0;
         hresp <= 1'b0;
      end
      else if (state == BUS_WAIT && !p_write)
      begin
         hrdata <= {24'h0, read_mux};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers; the power-on flag holds all but itself and the oscillator status at zero.

   // Control one: select field, test bit and storage bits.
   always_ff @(posedge clock)
   begin
      if (rst || power_on_flag)
         control_one <= CONTROL_RESET;
      else if (wr_one)
         control_one <= wdata;
   end

   // Adjustment register.
   always_ff @(posedge clock)
   begin
      if (rst || power_on_flag)
         adjust <= CONTROL_RESET;
      else if (wr_adjust)
         adjust <= wdata;
   end

   // Threshold select and spare bit.
   always_ff @(posedge clock)
   begin
      if (rst || power_on_flag)
      begin
         supply_threshold <= 1'b0;
         spare_bit_one <= 1'b0;
      end
      else if (wr_two)
      begin
         supply_threshold <= wdata[THRESHOLD_BIT];
         spare_bit_one <= wdata[SPARE_ONE_BIT];
      end
   end

   // Power-on flag: set by reset or the power-up pin, cleared by writing 0.
   always_ff @(posedge clock)
   begin
      if (rst)
         power_on_flag <= POWER_ON_RESET;
      else if (pins[3])
         power_on_flag <= 1'b1;
      else if (wr_two && !wdata[POWER_ON_BIT])
         power_on_flag <= 1'b0;
   end

   // Oscillator status: free read/write, a sensed halt wins and forces 0.
   always_ff @(posedge clock)
   begin
      if (rst)
         osc_running_status <= OSC_STATUS_RESET;
      else if (pins[2])
         osc_running_status <= 1'b0;
      else if (wr_two)
         osc_running_status <= wdata[OSC_STATUS_BIT];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Supply monitor.

   level_sync #(.WIDTH(4)) u_sync (
      .clock(clock),
      .rst(rst),
      .async_in({power_up_detect, osc_halt_sense, supply_below_low, supply_below_high}),
      .sync_out(pins)
   );

   // Flag sets on the selected comparator while monitoring; sensing wins.
   always_ff @(posedge clock)
   begin
      if (rst || power_on_flag)
         low_voltage_flag <= 1'b0;
      else if (monitor_enable && (supply_threshold ? pins[1] : pins[0]))
         low_voltage_flag <= 1'b1;
      else if (wr_two && !wdata[LOW_VOLTAGE_BIT])
         low_voltage_flag <= 1'b0;
   end

   // Pin-level outputs; the monitor stops while the flag is set.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         monitor_enable <= 1'b0;
         supply_threshold_select <= 1'b0;
         test_mode <= 1'b0;
         adjust_step_select <= 1'b0;
      end
      else
      begin
         monitor_enable <= !low_voltage_flag;
         supply_threshold_select <= supply_threshold;
         test_mode <= control_one[TEST_BIT];
         adjust_step_select <= adjust[ADJ_STEP_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Time base: divider, seconds and oscillation adjustment.

   subsecond_divider #(.QUARTER(QUARTER), .CW(CW)) u_div (
      .clock(clock),
      .rst(rst),
      .clear(wr_seconds),
      .stretch((stall != '0) && !adjust[ADJ_SIGN_BIT]),
      .hurry((stall != '0) && adjust[ADJ_SIGN_BIT]),
      .count(div_count),
      .quarter(quarter)
   );

   // The increment trails the start of the second by the fixed lag.
   always_comb
   begin
      second_inc = (quarter == 2'h0) && (div_count == CW'(INC_DELAY));
      periodic_select = periodic_mode_t'(control_one[2:0]);
      case (periodic_select)
         MODE_EVERY_SECOND: level_event = second_inc;
         MODE_EVERY_MINUTE: level_event = second_inc && (seconds == SECONDS_LAST);
         MODE_EVERY_HOUR: level_event = second_inc && (seconds == SECONDS_LAST)
                                        && minute_is_zero;
         MODE_EVERY_MONTH: level_event = second_inc && (seconds == SECONDS_LAST)
                                         && minute_is_zero && hour_is_zero && day_is_first;
         default: level_event = 1'b0;
      endcase
   end

   // Seconds counter; a write loads it and restarts the second.
   always_ff @(posedge clock)
   begin
      if (rst)
         seconds <= 6'h0;
      else if (wr_seconds)
         seconds <= wdata[5:0];
      else if (second_inc)
         seconds <= (seconds == SECONDS_LAST) ? 6'h0 : seconds + 6'h1;
   end

   // Adjustment: every 20 or 60 s the next second is lengthened or shortened.
   always_ff @(posedge clock)
   begin
      if (rst || wr_seconds)
         stall <= '0;
      else if (second_inc && (adjust[5:0] != 6'h0)
               && ((6'(seconds + 6'h1) % (adjust[ADJ_STEP_BIT] ? ADJ_COARSE_PERIOD_S
                                                             : ADJ_FINE_PERIOD_S)) == 6'h0))
         stall <= SW'(adjust[5:0]) * SW'(ADJ_STEP);
      else if (stall != '0)
         stall <= stall - SW'(1);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Periodic output.

   // Level request: set wins over a release written in the same cycle.
   always_ff @(posedge clock)
   begin
      if (rst || !periodic_select[2])
         level_latch <= 1'b0;
      else if (level_event)
         level_latch <= 1'b1;
      else if (wr_two && !wdata[PERIODIC_FLAG_BIT])
         level_latch <= 1'b0;
   end

   // Wanted output per mode; the pulse falls at the start of the second.
   always_comb
   begin
      case (periodic_select)
         MODE_OFF: periodic_low = 1'b0;
         MODE_FIXED_LOW: periodic_low = 1'b1;
         MODE_PULSE_2HZ: periodic_low = !quarter[0];
         MODE_PULSE_1HZ: periodic_low = !quarter[1];
         default: periodic_low = level_latch;
      endcase
   end

   // Output and tick flops; power-on flag forces the output off.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         irq_out_n <= 1'b1;
         second_tick <= 1'b0;
      end
      else
      begin
         irq_out_n <= !(periodic_low && !power_on_flag);
         second_tick <= second_inc;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   sequence s_seconds_write;
      wr_seconds && periodic_select[2:1] == 2'b01 && !power_on_flag;
   endsequence

   sequence s_output_low_two;
      !irq_out_n [*2];
   endsequence

   AST_OFF_HIGH: assert property (@(posedge clock) disable iff (rst)
      (periodic_select == MODE_OFF) |=> irq_out_n)
      else $error("Output low with periodic select off.");

   AST_FIXED_LOW: assert property (@(posedge clock) disable iff (rst)
      (periodic_select == MODE_FIXED_LOW && !power_on_flag) [*2] |=> !irq_out_n)
      else $error("Output not low in fixed-low mode.");

   AST_INC_WHILE_LOW: assert property (@(posedge clock) disable iff (rst)
      (second_inc && periodic_select[2:1] == 2'b01 && !power_on_flag
       && $stable(periodic_select)) |-> !irq_out_n)
      else $error("Second increment outside the low half of the pulse.");

   AST_CLEAR_LOW: assert property (@(posedge clock) disable iff (rst)
      s_seconds_write ##1 (periodic_select[2:1] == 2'b01 && !power_on_flag)
      |=> s_output_low_two)
      else $error("Seconds write did not drive the pulse output low.");

   AST_LEVEL_FALL: assert property (@(posedge clock) disable iff (rst)
      (level_event && !power_on_flag) ##1 (periodic_select[2] && !power_on_flag)
      |=> !irq_out_n)
      else $error("Level interrupt did not fall with the increment.");

   AST_LOWV_STICKY: assert property (@(posedge clock) disable iff (rst)
      (low_voltage_flag && !power_on_flag && !wr_two) |=> low_voltage_flag ##1 !monitor_enable)
      else $error("Low-voltage flag dropped or monitor kept running.");

   AST_LOWV_W1: assert property (@(posedge clock) disable iff (rst)
      (!low_voltage_flag && wr_two && wdata[LOW_VOLTAGE_BIT] && !pins[0] && !pins[1])
      |=> !low_voltage_flag)
      else $error("Writing one set the low-voltage flag.");

   AST_OSC_FORCED: assert property (@(posedge clock) disable iff (rst)
      pins[2] |=> !osc_running_status)
      else $error("Oscillator status not forced to zero on halt.");

   AST_PON_HOLD: assert property (@(posedge clock) disable iff (rst)
      power_on_flag |=> (control_one == 8'h00 && adjust == 8'h00 && !spare_bit_one)
                        ##1 irq_out_n)
      else $error("Power-on flag did not hold the control bits at zero.");

   AST_PON_W1: assert property (@(posedge clock) disable iff (rst)
      (!power_on_flag && !pins[3]) |=> !power_on_flag)
      else $error("Power-on flag set without a power-up event.");

endmodule : rtc_periodic_irq

//--- dv/irq_host_model.sv
// Host model that watches the active-low periodic interrupt line.
`timescale 1ns/100ps
module irq_host_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic irq_out_n,
   output int falls,
   output int low_cycles
);
   logic last;
   // Count falling edges and low cycles; the bench compares the counts taken over a window.
   always_ff @(posedge clock)
   begin
      last <= irq_out_n;
      if (rst)
      begin
         falls <= 0;
         low_cycles <= 0;
      end
      else
      begin
         if (last && !irq_out_n)
            falls <= falls + 1;
         if (!irq_out_n)
            low_cycles <= low_cycles + 1;
      end
   end
endmodule : irq_host_model

//--- dv/testbench.sv
// Self-checking bench for the periodic interrupt and status block.
`timescale 1ns/100ps
module testbench;
   import rtc_periodic_pkg::*;
   localparam int Q = 40;
   localparam int LAG = 5;
   logic clock = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic hready, hresp, irq_n, thr, mon, tmode, astep, tick;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic hi = 1'b0, lo = 1'b0, halt = 1'b0, pup = 1'b0, mz = 1'b0, hz = 1'b0, dz = 1'b0;
   int miscompares = 0, n_compared = 0, falls, lows, f0, l0, n, k;
   int thr_m = 0, lv_m = 0, osc_m = 0, pon_m = 1, sp_m = 0;
   logic [7:0] d;

   // The clock toggles every half period.
   always #2 clock = ~clock;

   rtc_periodic_irq #(.QUARTER(Q), .INC_DELAY(LAG), .ADJ_STEP(1)) DUT (
      .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
      .supply_below_high(hi), .supply_below_low(lo), .osc_halt_sense(halt),
      .power_up_detect(pup), .minute_is_zero(mz), .hour_is_zero(hz),
      .day_is_first(dz), .irq_out_n(irq_n), .supply_threshold_select(thr),
      .monitor_enable(mon), .test_mode(tmode), .adjust_step_select(astep),
      .second_tick(tick));
   irq_host_model host (.clock(clock), .rst(rst), .irq_out_n(irq_n), .falls(falls),
      .low_cycles(lows));

   task automatic end_of_test();
      $display("Compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_of_test

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic edges(input int k);
      repeat (k) @(posedge clock);
   endtask : edges

   // One AHB-Lite single transfer; waits for hready in both phases.
   task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] v);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {26'h0, idx, 2'h0};
      @(posedge clock);
      while (hready !== 1'b1) @(posedge clock);
      htrans <= 2'h0;
      hwdata <= {24'h0, v};
      @(posedge clock);
      while (hready !== 1'b1) @(posedge clock);
      rd = hrdata;
   endtask : bus

   task automatic rdc(input string what, input logic [3:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h00);
      chk(what, rd, {24'h0, e});
      chk("okay response", hresp, 1'b0);
   endtask : rdc

   // Write the second status register and update the bench model.
   task automatic wr2(input logic [7:0] v);
      bus(1'b1, 4'hf, v);
      if (!v[4]) pon_m = 0;
      if (!v[6]) lv_m = 0;
      osc_m = v[5];
      thr_m = pon_m ? 0 : v[7];
      sp_m = pon_m ? 0 : v[3];
   endtask : wr2

   function automatic logic [7:0] cs2(input logic f);
      return {thr_m[0], lv_m[0], osc_m[0], pon_m[0], sp_m[0], f, 2'b00};
   endfunction : cs2

   task automatic wait_on(ref logic s, input logic v);
      n = 0;
      while (s !== v && n < 5 * Q)
      begin
         @(posedge clock);
         n++;
      end
      // A wait that runs out is counted as a mismatch.
      if (s !== v)
         chk("wait level", s, v);
   endtask : wait_on

   initial
   begin
      #100000;
      miscompares++;
      end_of_test();
   end

   initial
   begin
      n = $urandom(32'h6926a744);
      edges(16);
      rst <= 1'b0;
      rdc("status after reset", 4'hf, 8'h10);
      bus(1'b1, 4'he, 8'h0b);
      rdc("control one held", 4'he, 8'h00);
      wr2(8'h98);
      rdc("power-on write one", 4'hf, cs2(1'b0));
      wr2(8'h00);
      rdc("power-on cleared", 4'hf, cs2(1'b0));
      d = 8'($urandom) & 8'ha8;
      wr2(d | 8'h40);
      rdc("status random", 4'hf, cs2(1'b0));
      chk("threshold pin", thr, d[7]);
      bus(1'b1, 4'he, 8'h08);
      // The pin copy settles one edge after the register write.
      edges(1);
      chk("test mode pin", tmode, 1'b1);
      bus(1'b1, 4'he, 8'h01);
      edges(3);
      chk("fixed low", irq_n, 1'b0);
      rdc("flag when low", 4'hf, cs2(1'b1));
      bus(1'b1, 4'he, 8'h00);
      edges(3);
      chk("off high", irq_n, 1'b1);
      for (int m = 2; m < 4; m++)
      begin
         bus(1'b1, 4'he, 8'(m));
         bus(1'b1, 4'h0, 8'h00);
         edges(3);
         chk("seconds write", irq_n, 1'b0);
         wait_on(irq_n, 1'b1);
         wait_on(irq_n, 1'b0);
         wait_on(tick, 1'b1);
         if (m == 3)
            chk("tick lag", n, LAG);
         f0 = falls;
         l0 = lows;
         edges(4 * Q);
         chk("low cycles", lows - l0, 2 * Q);
         chk("pulse falls", falls - f0, 4 - m);
      end
      for (int m = 4; m < 8; m++)
      begin
         {dz, hz, mz} <= 3'b000;
         bus(1'b1, 4'he, 8'(m));
         wr2(cs2(1'b0));
         bus(1'b1, 4'h0, SECONDS_LAST);
         f0 = falls;
         edges(5 * Q);
         // The step from 59 to 00 is an event for the second and minute modes.
         chk("quiet falls", falls - f0, m < 6);
         {dz, hz, mz} <= 3'b111;
         wr2(cs2(1'b0));
         edges(2);
         chk("flag release", irq_n, 1'b1);
         bus(1'b1, 4'h0, SECONDS_LAST);
         wait_on(tick, 1'b1);
         chk("level before", irq_n, 1'b1);
         edges(1);
         chk("level fall", irq_n, 1'b0);
         rdc("level flag", 4'hf, cs2(1'b1));
      end
      // Stretch the second after 59 by a random count; the 1 Hz low half grows.
      k = 1 + $urandom % 20;
      bus(1'b1, 4'h7, 8'h80 | 8'(k));
      edges(1);
      chk("step select pin", astep, 1'b1);
      bus(1'b1, 4'he, 8'h03);
      bus(1'b1, 4'h0, SECONDS_LAST);
      edges(3);
      wait_on(irq_n, 1'b1);
      chk("stretched low", n, 2 * Q - 2 + k);
      bus(1'b1, 4'he, 8'h00);
      hi <= 1'b1;
      lo <= 1'b1;
      edges(4);
      hi <= 1'b0;
      lo <= 1'b0;
      lv_m = 1;
      rdc("low voltage", 4'hf, cs2(1'b0));
      chk("monitor off", mon, 1'b0);
      wr2(cs2(1'b0));
      rdc("low voltage kept", 4'hf, cs2(1'b0));
      wr2(cs2(1'b0) & 8'hbf);
      edges(2);
      chk("monitor on", mon, 1'b1);
      wr2(8'h28);
      halt <= 1'b1;
      edges(4);
      halt <= 1'b0;
      osc_m = 0;
      rdc("osc halt", 4'hf, cs2(1'b0));
      bus(1'b1, 4'he, 8'h01);
      pup <= 1'b1;
      edges(4);
      pup <= 1'b0;
      pon_m = 1;
      thr_m = 0;
      sp_m = 0;
      edges(4);
      rdc("power up", 4'hf, cs2(1'b0));
      rdc("power up control", 4'he, 8'h00);
      chk("power up irq", irq_n, 1'b1);
      bus(1'b1, 4'hd, 8'hff);
      rdc("unmapped", 4'hd, 8'h00);
      end_of_test();
   end
endmodule : testbench
